// *** test/smid_host_model.sv ***
// serial host model for the identification register link
`timescale 1ns/1ps
`default_nettype none
module smid_host_model (
    input wire logic ref_clk,
    input wire logic smb_data_oe,
    output logic smb_clk,
    output logic smb_data
);
    // ----------------------------------------------------------------
    // wire level and timing
    // ----------------------------------------------------------------
    localparam int PH = 6;
    logic host_sda;
    // open drain with pull-up: released line reads high
    assign smb_data = host_sda & ~smb_data_oe;
    initial begin
        host_sda = 1'b1;
        smb_clk = 1'b1;
    end
    task automatic hold();
        repeat (PH) @(posedge ref_clk);
    endtask
    // ----------------------------------------------------------------
    // line conditions and bits
    // ----------------------------------------------------------------
    task automatic start_cond();
        host_sda <= 1'b1;
        hold();
        smb_clk <= 1'b1;
        hold();
        host_sda <= 1'b0;
        hold();
        smb_clk <= 1'b0;
        hold();
    endtask
    task automatic stop_cond();
        host_sda <= 1'b0;
        hold();
        smb_clk <= 1'b1;
        hold();
        host_sda <= 1'b1;
        hold();
    endtask
    task automatic bit_out(input logic b);
        host_sda <= b;
        hold();
        smb_clk <= 1'b1;
        hold();
        smb_clk <= 1'b0;
        hold();
    endtask
    task automatic bit_in(output logic b);
        host_sda <= 1'b1;
        hold();
        smb_clk <= 1'b1;
        repeat (3) @(posedge ref_clk);
        b = smb_data;
        repeat (3) @(posedge ref_clk);
        smb_clk <= 1'b0;
        hold();
    endtask
    // ----------------------------------------------------------------
    // bytes
    // ----------------------------------------------------------------
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic nak;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(nak);
        ack = ~nak;
    endtask
    // acks each byte except the last one, which it nacks
    task automatic recv_byte(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(last);
    endtask
endmodule // smid_host_model
`default_nettype wire

// *** test/smid_id_regs_bench.sv ***
// self-checking bench for the identification register slave
`timescale 1ns/1ps
`default_nettype none
module smid_id_regs_bench;
    import smid_pkg::*;
    // identity values chosen for this build, arbitrary
    localparam logic [7:0] EXP_REV_VENDOR = 8'h39;
    localparam logic [7:0] EXP_CLASS_NUMBER = 8'h2a;
    logic ref_clk;
    logic sys_rst;
    logic smb_clk_in;
    logic smb_data_in;
    logic smb_data_out;
    logic smb_data_oe;
    logic [4:0] block_read_length;
    logic [7:0] got[6];
    logic ack;
    int n_mismatch = 0;
    int comparisons = 0;
    // ----------------------------------------------------------------
    // instances
    // ----------------------------------------------------------------
    smid_id_regs #(.SLAVE_ADDR(SMID_DEFAULT_ADDR)) smid_id_regs_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .smb_clk_in(smb_clk_in),
        .smb_data_in(smb_data_in), .smb_data_out(smb_data_out),
        .smb_data_oe(smb_data_oe), .block_read_length(block_read_length));
    smid_host_model host_i (.ref_clk(ref_clk), .smb_data_oe(smb_data_oe),
        .smb_clk(smb_clk_in), .smb_data(smb_data_in));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // sends n bytes of d, most significant byte first
    task automatic wr_frame(input logic [7:0] idx, input logic [31:0] d,
        input int n, output logic all_ack);
        logic a;
        host_i.start_cond();
        host_i.send_byte({SMID_DEFAULT_ADDR, 1'b0}, all_ack);
        host_i.send_byte(idx, a);
        all_ack &= a;
        for (int i = 0; i < n; i++) begin
            host_i.send_byte(d[31-8*i -: 8], a);
            all_ack &= a;
        end
        host_i.stop_cond();
    endtask
    // got[0] is the count byte, then n data bytes
    task automatic rd_frame(input logic [7:0] idx, input int n,
        output logic [7:0] q[6], output logic all_ack);
        logic a;
        logic [7:0] b;
        host_i.start_cond();
        host_i.send_byte({SMID_DEFAULT_ADDR, 1'b0}, all_ack);
        host_i.send_byte(idx, a);
        all_ack &= a;
        host_i.start_cond();
        host_i.send_byte({SMID_DEFAULT_ADDR, 1'b1}, a);
        all_ack &= a;
        for (int i = 0; i <= n; i++) begin
            host_i.recv_byte(b, i == n);
            q[i] = b;
        end
        host_i.stop_cond();
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check("length after reset", {3'h0, block_read_length}, 8'h08);
        check("data out", {7'h0, smb_data_out}, 8'h00);
        check("data oe idle", {7'h0, smb_data_oe}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_read_ids();
        rd_frame(8'h03, 5, got, ack);
        check("read acks", {7'h0, ack}, 8'h01);
        check("count byte", got[0], {SMID_LENGTH_PAD, SMID_LENGTH_RESET});
        check("unmapped byte", got[1], SMID_UNMAPPED_VALUE);
        check("reserved byte", got[2], SMID_RESERVED_VALUE);
        check("rev vendor", got[3], EXP_REV_VENDOR);
        check("class number", got[4], EXP_CLASS_NUMBER);
        check("length byte", got[5], 8'h08);
        $display("test read ids done");
    endtask
    task automatic t_write_ids();
        wr_frame(SMID_IDX_RESERVED, 32'h0300550a, 4, ack);
        check("id write acks", {7'h0, ack}, 8'h01);
        rd_frame(SMID_IDX_RESERVED, 3, got, ack);
        check("count kept", got[0], 8'h08);
        check("reserved kept", got[1], SMID_RESERVED_VALUE);
        check("rev vendor kept", got[2], EXP_REV_VENDOR);
        check("class kept", got[3], EXP_CLASS_NUMBER);
        $display("test write ids done");
    endtask
    task automatic t_write_len();
        logic [7:0] vals[2] = '{8'hf3, 8'h03};
        foreach (vals[i]) begin
            wr_frame(SMID_IDX_READ_LENGTH, {8'h01, vals[i], 16'h0000}, 2,
                ack);
            check("length write acks", {7'h0, ack}, 8'h01);
            check("length port", {3'h0, block_read_length},
                vals[i] & 8'h1f);
            rd_frame(SMID_IDX_REV_VENDOR, 3, got, ack);
            check("new count", got[0], vals[i] & 8'h1f);
            check("first byte", got[1], EXP_REV_VENDOR);
            check("second byte", got[2], EXP_CLASS_NUMBER);
            check("length readback", got[3], vals[i] & 8'h1f);
        end
        $display("test write length done");
    endtask
    task automatic t_bad_addr();
        host_i.start_cond();
        host_i.send_byte({SMID_DEFAULT_ADDR ^ 7'h01, 1'b0}, ack);
        check("foreign address ack", {7'h0, ack}, 8'h00);
        host_i.send_byte(8'h07, ack);
        check("ignored byte ack", {7'h0, ack}, 8'h00);
        host_i.stop_cond();
        $display("test bad address done");
    endtask
    // ----------------------------------------------------------------
    // clock, reset, sequence
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_mismatch++;
        $display("run limit reached");
        give_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        t_reset();
        t_read_ids();
        t_write_ids();
        t_write_len();
        t_bad_addr();
        give_verdict();
    end
endmodule // smid_id_regs_bench
`default_nettype wire

// *** verilog/smid_id_regs.sv ***
// serial management slave serving the identification and length bytes
// Summary of operation
// - index 4 always reads all ones
// - index 5 gives fixed revision and vendor
// - index 6 gives fixed class and number
// - index 7 low five bits writable, default eight
// - block read sends count, then bytes from index
`timescale 1ns/1ps
`default_nettype none
module smid_id_regs
    import smid_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = SMID_DEFAULT_ADDR
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic smb_clk_in,
    input wire logic smb_data_in,
    output logic smb_data_out,
    output logic smb_data_oe,
    output logic [4:0] block_read_length
);

    logic clk_meta_reg, clk_sync_reg, clk_prev_reg;
    logic data_meta_reg, data_sync_reg, data_prev_reg;
    logic clk_rise, clk_fall, start_seen, stop_seen;
    smid_state_type state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [7:0] index_reg;
    logic [1:0] byte_num_reg;
    logic read_dir_reg, host_ack_reg;
    logic oe_reg, out_reg;
    logic wr_en;
    logic [7:0] rd_data;
    logic [4:0] read_length;
    logic [4:0] length_out_reg;
    logic addr_match;

    // ------------------------------------------------------------
    // pin synchronisers and line events
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clk_meta_reg <= 1'b1;
            clk_sync_reg <= 1'b1;
            clk_prev_reg <= 1'b1;
            data_meta_reg <= 1'b1;
            data_sync_reg <= 1'b1;
            data_prev_reg <= 1'b1;
        end else begin
            clk_meta_reg <= smb_clk_in;
            clk_sync_reg <= clk_meta_reg;
            clk_prev_reg <= clk_sync_reg;
            data_meta_reg <= smb_data_in;
            data_sync_reg <= data_meta_reg;
            data_prev_reg <= data_sync_reg;
        end
    end

    assign clk_rise = clk_sync_reg && !clk_prev_reg;
    assign clk_fall = !clk_sync_reg && clk_prev_reg;
    assign start_seen = clk_sync_reg && clk_prev_reg
                        && data_prev_reg && !data_sync_reg;
    assign stop_seen = clk_sync_reg && clk_prev_reg
                       && !data_prev_reg && data_sync_reg;
    assign addr_match = shift_reg[7:1] == SLAVE_ADDR;
    assign wr_en = clk_fall && state_reg == SMID_RECV
                   && bit_cnt_reg == SMID_ACK_BIT
                   && byte_num_reg == SMID_BYTE_DATA;

    // ------------------------------------------------------------
    // bit counter and receive shifter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            host_ack_reg <= 1'b0;
        end else if (start_seen || stop_seen) begin
            bit_cnt_reg <= 4'h0;
        end else if (clk_rise && state_reg != SMID_IDLE
                     && state_reg != SMID_WAIT) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg < SMID_ACK_BIT) begin
                shift_reg <= {shift_reg[6:0], data_sync_reg};
            end
            if (bit_cnt_reg == SMID_ACK_BIT) begin
                host_ack_reg <= !data_sync_reg;
            end
        end else if (clk_fall && bit_cnt_reg == SMID_FRAME_END) begin
            bit_cnt_reg <= 4'h0;
        end
    end

    // ------------------------------------------------------------
    // transfer state machine
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= SMID_IDLE;
            read_dir_reg <= 1'b0;
            byte_num_reg <= SMID_BYTE_INDEX;
            index_reg <= 8'h00;
            tx_reg <= 8'h00;
        end else if (stop_seen) begin
            state_reg <= SMID_IDLE;
        end else if (start_seen) begin
            state_reg <= SMID_ADDR;
        end else if (clk_fall) begin
            case (state_reg)
                SMID_ADDR: begin
                    if (bit_cnt_reg == SMID_ACK_BIT) begin
                        read_dir_reg <= shift_reg[0];
                        if (!addr_match) begin
                            state_reg <= SMID_WAIT;
                        end
                    end else if (bit_cnt_reg == SMID_FRAME_END) begin
                        if (read_dir_reg) begin
                            state_reg <= SMID_SEND;
                            tx_reg <= {SMID_LENGTH_PAD, read_length};
                        end else begin
                            state_reg <= SMID_RECV;
                            byte_num_reg <= SMID_BYTE_INDEX;
                        end
                    end
                end
                SMID_RECV: begin
                    if (bit_cnt_reg == SMID_ACK_BIT) begin
                        if (byte_num_reg == SMID_BYTE_INDEX) begin
                            index_reg <= shift_reg;
                        end else if (byte_num_reg == SMID_BYTE_DATA) begin
                            index_reg <= index_reg + 8'h01;
                        end
                        if (byte_num_reg != SMID_BYTE_DATA) begin
                            byte_num_reg <= byte_num_reg + 2'h1;
                        end
                    end
                end
                SMID_SEND: begin
                    if (bit_cnt_reg == SMID_FRAME_END) begin
                        if (host_ack_reg) begin
                            tx_reg <= rd_data;
                            index_reg <= index_reg + 8'h01;
                        end else begin
                            state_reg <= SMID_WAIT;
                        end
                    end
                end
                SMID_IDLE, SMID_WAIT: begin
                    state_reg <= state_reg;
                end
                default: begin
                    state_reg <= SMID_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // open-drain data driver, changes on clock fall, released on start or stop
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            oe_reg <= 1'b0;
            out_reg <= 1'b0;
        end else if (start_seen || stop_seen) begin
            oe_reg <= 1'b0;
        end else if (clk_fall) begin
            out_reg <= 1'b0;
            if (state_reg == SMID_ADDR && bit_cnt_reg == SMID_ACK_BIT) begin
                oe_reg <= addr_match;
            end else if (state_reg == SMID_RECV
                         && bit_cnt_reg == SMID_ACK_BIT) begin
                oe_reg <= 1'b1;
            end else if (state_reg == SMID_ADDR && read_dir_reg
                         && bit_cnt_reg == SMID_FRAME_END) begin
                oe_reg <= !SMID_LENGTH_PAD[2];
            end else if (state_reg == SMID_SEND
                         && bit_cnt_reg == SMID_FRAME_END) begin
                oe_reg <= host_ack_reg && !rd_data[7];
            end else if (state_reg == SMID_SEND
                         && bit_cnt_reg < SMID_ACK_BIT) begin
                oe_reg <= !tx_reg[3'h7 - bit_cnt_reg[2:0]];
            end else begin
                oe_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            length_out_reg <= SMID_LENGTH_RESET;
        end else begin
            length_out_reg <= read_length;
        end
    end

    assign smb_data_oe = oe_reg;
    assign smb_data_out = out_reg;
    assign block_read_length = length_out_reg;

    smid_reg_bank u_bank (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wr_en(wr_en),
        .wr_index(index_reg),
        .wr_data(shift_reg),
        .rd_index(index_reg),
        .rd_data(rd_data),
        .read_length(read_length)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_count_sent_first: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        clk_fall && !start_seen && !stop_seen && state_reg == SMID_ADDR
        && read_dir_reg && bit_cnt_reg == SMID_FRAME_END |=>
        state_reg == SMID_SEND && tx_reg == {3'h0, $past(read_length)})
        else $error("block read did not start with the count");
    a_count_msb_low: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        clk_fall && !start_seen && !stop_seen && state_reg == SMID_ADDR
        && read_dir_reg && bit_cnt_reg == SMID_FRAME_END |=> oe_reg)
        else $error("count byte msb not driven low");
    a_next_byte_indexed: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        clk_fall && !start_seen && !stop_seen && state_reg == SMID_SEND
        && bit_cnt_reg == SMID_FRAME_END && host_ack_reg |=>
        tx_reg == $past(rd_data) && index_reg == $past(index_reg) + 8'h01)
        else $error("block read byte not taken from current index");
    a_write_acked: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        wr_en && !start_seen && !stop_seen |=> oe_reg)
        else $error("data write was not acknowledged");
    c_block_read: cover property (
        @(posedge ref_clk) disable iff (sys_rst)
        state_reg == SMID_SEND && host_ack_reg);
    c_read_ended: cover property (
        @(posedge ref_clk) disable iff (sys_rst)
        state_reg == SMID_SEND ##1 state_reg == SMID_WAIT);
    c_foreign_addr: cover property (
        @(posedge ref_clk) disable iff (sys_rst)
        state_reg == SMID_ADDR ##1 state_reg == SMID_WAIT);

endmodule // smid_id_regs
`default_nettype wire

// *** verilog/smid_pkg.sv ***
// constants and types shared by the identification register bank
package smid_pkg;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [7:0] SMID_IDX_RESERVED = 8'h04;
    localparam logic [7:0] SMID_IDX_REV_VENDOR = 8'h05;
    localparam logic [7:0] SMID_IDX_CLASS_NUMBER = 8'h06;
    localparam logic [7:0] SMID_IDX_READ_LENGTH = 8'h07;

    // ------------------------------------------------------------
    // values and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] SMID_RESERVED_VALUE = 8'hff;
    localparam logic [7:0] SMID_UNMAPPED_VALUE = 8'h00;
    localparam int SMID_LENGTH_W = 5;
    localparam logic [4:0] SMID_LENGTH_RESET = 5'h08;
    localparam logic [2:0] SMID_LENGTH_PAD = 3'h0;
    localparam int SMID_REV_LSB = 4;
    localparam int SMID_CLASS_LSB = 6;

    // ------------------------------------------------------------
    // serial framing
    // ------------------------------------------------------------
    localparam logic [3:0] SMID_ACK_BIT = 4'h8;
    localparam logic [3:0] SMID_FRAME_END = 4'h9;
    localparam logic [1:0] SMID_BYTE_INDEX = 2'h0;
    localparam logic [1:0] SMID_BYTE_COUNT = 2'h1;
    localparam logic [1:0] SMID_BYTE_DATA = 2'h2;
    localparam logic [6:0] SMID_DEFAULT_ADDR = 7'h2a;

    typedef enum logic [2:0] {
        SMID_IDLE = 3'b000,
        SMID_ADDR = 3'b001,
        SMID_RECV = 3'b011,
        SMID_SEND = 3'b010,
        SMID_WAIT = 3'b110
    } smid_state_type;

endpackage

// *** verilog/smid_reg_bank.sv ***
// identification bytes and block read length register
`timescale 1ns/1ps
`default_nettype none
module smid_reg_bank
    import smid_pkg::*;
#(
    // identity values below are arbitrary
    parameter logic [3:0] REVISION_CODE = 4'h3,
    parameter logic [3:0] VENDOR_CODE = 4'h9,
    parameter logic [1:0] DEVICE_CLASS = 2'h0,
    parameter logic [5:0] DEVICE_NUMBER = 6'h2a
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [7:0] wr_index,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_index,
    output logic [7:0] rd_data,
    output logic [4:0] read_length
);

    logic [4:0] length_reg;

    // ------------------------------------------------------------
    // writable length, id bytes ignore writes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            length_reg <= SMID_LENGTH_RESET;
        end else if (wr_en && wr_index == SMID_IDX_READ_LENGTH) begin
            length_reg <= wr_data[SMID_LENGTH_W-1:0];
        end
    end

    assign read_length = length_reg;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        case (rd_index)
            SMID_IDX_RESERVED: rd_data = SMID_RESERVED_VALUE;
            SMID_IDX_REV_VENDOR: rd_data = {REVISION_CODE, VENDOR_CODE};
            SMID_IDX_CLASS_NUMBER: rd_data = {DEVICE_CLASS, DEVICE_NUMBER};
            SMID_IDX_READ_LENGTH: rd_data = {SMID_LENGTH_PAD, length_reg};
            default: rd_data = SMID_UNMAPPED_VALUE;
        endcase
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_reserved_all_ones: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        rd_index == SMID_IDX_RESERVED |-> rd_data == 8'hff)
        else $error("reserved index did not read all ones");
    a_revision_vendor_fixed: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        rd_index == SMID_IDX_REV_VENDOR |->
        rd_data[7:SMID_REV_LSB] == REVISION_CODE
        && rd_data[SMID_REV_LSB-1:0] == VENDOR_CODE)
        else $error("revision and vendor byte wrong");
    a_class_number_fixed: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        rd_index == SMID_IDX_CLASS_NUMBER |->
        rd_data[7:SMID_CLASS_LSB] == DEVICE_CLASS
        && rd_data[SMID_CLASS_LSB-1:0] == DEVICE_NUMBER)
        else $error("class and number byte wrong");
    a_length_write_read: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        wr_en && wr_index == SMID_IDX_READ_LENGTH |=>
        length_reg == $past(wr_data[SMID_LENGTH_W-1:0]))
        else $error("length write did not land");
    a_length_pad_zero: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        rd_index == SMID_IDX_READ_LENGTH |->
        rd_data[7:SMID_LENGTH_W] == 3'h0
        && rd_data[SMID_LENGTH_W-1:0] == length_reg)
        else $error("length byte pad bits not zero");
    a_id_write_ignored: assert property (
        @(posedge ref_clk) disable iff (sys_rst)
        wr_en && wr_index != SMID_IDX_READ_LENGTH |=> $stable(length_reg))
        else $error("write to read-only index changed state");
    c_length_written: cover property (
        @(posedge ref_clk) disable iff (sys_rst)
        wr_en && wr_index == SMID_IDX_READ_LENGTH);

endmodule // smid_reg_bank
`default_nettype wire
